//--- src/gtm_pkg.sv
// Shared constants and carriers for the timer interrupt and port block
package gtm_pkg;
	localparam int NSRC = 11;
	localparam int AW = 8;
	// Register byte addresses
	localparam logic [7:0] A_MCR = 8'h00;
	localparam logic [7:0] A_ISR = 8'h04;
	localparam logic [7:0] A_MSK = 8'h08;
	localparam logic [7:0] A_FLG = 8'h0C;
	localparam logic [7:0] A_DIR = 8'h10;
	localparam logic [7:0] A_DAT = 8'h14;
	localparam logic [7:0] A_ACC = 8'h18;
	localparam logic [7:0] A_FRC = 8'h1C;
	localparam logic [7:0] A_MOD = 8'h20;
	localparam logic [7:0] A_FUN = 8'h24;
	localparam logic [7:0] A_SCC = 8'h28;
	// Interrupt setup fields
	localparam int ISR_LVL = 0;
	localparam int ISR_VB = 4;
	localparam int ISR_PA = 8;
	// Accumulator control status bits
	localparam int ACC_ACCUMULATOR_PIN_STATE = 7;
	localparam int ACC_EXT_CLOCK_PIN_STATE = 6;
	// Modulator control bits
	localparam int MOD_PPROUT = 0;
	localparam int MOD_F1A = 1;
	localparam int MOD_F1B = 2;
	localparam int MOD_GPA = 3;
	localparam int MOD_GPB = 4;
	// Compare force bits
	localparam int FRC_FA = 0;
	localparam int FRC_FB = 1;
	// Function config fields
	localparam int FUN_CAP = 8;
	localparam int FUN_ROLE = 16;
	localparam int FUN_CPROUT = 17;
	// Port bit of the first compare and shared pins
	localparam int PIN_OC1 = 3;
	localparam int PIN_SHR = 7;
	localparam logic [3:0] SRC_ADJ = 4'h0;
	localparam logic [1:0] ARB_LAST = 2'h3;
	typedef enum {ST_IDLE, ST_ARB, ST_VEC} gtm_state_t;
	// Acknowledge cycle from the processor side
	typedef struct packed {
		logic start;
		logic [2:0] level;
		logic step;
		logic line;
		logic done;
	} gtm_ack_in_t;
	// Answer to the acknowledge cycle
	typedef struct packed {
		logic [7:0] vector;
		logic vec_oe;
		logic arb_out;
		logic arb_oe;
	} gtm_ack_out_t;
endpackage

//--- src/gtm_irq_port.sv
// Timer interrupt request, arbitration, vector and port pin logic
// Behaviour
// R01: Eleven sources, each requests only with its mask bit set.
// R02: Two 8-bit masks, byte or word access, zero at reset.
// R03: Mask bit aligns with flag bit; set flag and mask make request.
// R04: Three-bit level picks request line; 111 highest, 000 disables.
// R05: Source codes 0 adjusted, 1-3 captures, 4-7 compares, 8-11 others.
// R06: Matching acknowledge level makes block drive its arbitration bits serially.
// R07: Winner drives vector base nibble with source code, held stable.
// R08: Software loads vector base before enabling interrupts.
// R09: Lower source wins; adjusted source beats all, reported as 0000.
// R10: Request stays while any enabled flag remains set.
// R11: Flag clears by read then zero write; recurring event keeps it.
// R12: Processor accepts higher levels and drives acknowledged level out.
// R13: Pins pass pulses over two clocks, reject under one clock.
// R14: Shared pin register holds capture value or compare value by role.
// R15: Free first compare pin can output counter clock.
// R16: First modulator pin can output modulator counter clock.
// R17: Direction register bit per pin; only capture/compare pins bidirectional.
// R18: Port data read returns actual pin levels.
// R19: Port writes latch; driven when compare function off and output.
// R20: Port write can trigger capture on capture-configured pin.
// R21: Accumulator control shows accumulator and clock pin levels.
// R22: Modulator pins as outputs follow force value and force one.
// R23: Flags set only by events, never by processor writes.
// R24: Vector chosen from pending sources sampled at acknowledge start.
`timescale 1ns/1ps
`default_nettype none
module gtm_irq_port (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [gtm_pkg::AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [gtm_pkg::NSRC-1:0] event_pulse,
	output logic [6:0] irq_req_n,
	input wire gtm_pkg::gtm_ack_in_t ack_in,
	output gtm_pkg::gtm_ack_out_t ack_out,
	input wire logic [7:0] port_pin_in,
	output logic [7:0] port_pin_out,
	output logic [7:0] port_pin_oe,
	input wire logic [7:0] oc_level,
	output logic [7:0] port_level,
	output logic [7:0] capture_kick,
	input wire logic accumulator_input_pin,
	input wire logic ext_clock_pin,
	output logic accumulator_pin_state,
	output logic ext_clock_pin_state,
	input wire logic tcnt_clk_en,
	input wire logic pwm_clk_en,
	input wire logic [15:0] tcnt,
	input wire logic [1:0] pwm_wave,
	output logic modulator_out_a,
	output logic modulator_out_b,
	output logic [15:0] shared_cc_value
);
	import gtm_pkg::*;

	logic [3:0] arbitration_number;
	logic [11:0] interrupt_setup_register;
	logic [15:0] event_mask;
	logic [15:0] event_flags;
	logic [15:0] flag_armed;
	logic [7:0] port_direction_register;
	logic [7:0] port_data_register;
	logic [5:0] accumulator_control_register;
	logic [1:0] compare_force_register;
	logic [4:0] modulator_control_register;
	logic [17:0] func_cfg;
	logic [15:0] shared_cc;
	logic [9:0] sync_a;
	logic [9:0] sync_b;
	logic [9:0] sync_c;
	logic [9:0] filt;
	logic [9:0] filt_d;
	gtm_state_t state;
	logic [1:0] arb_bit;
	logic [7:0] vec_hold;

	// Bus decode
	wire setup = psel & ~penable;
	wire wr = psel & penable & pwrite;
	wire rd = psel & penable & ~pwrite;
	wire [7:0] ofs = paddr;
	wire hit_mcr = ofs == A_MCR;
	wire hit_isr = ofs == A_ISR;
	wire hit_msk = ofs == A_MSK;
	wire hit_flg = ofs == A_FLG;
	wire hit_dir = ofs == A_DIR;
	wire hit_dat = ofs == A_DAT;
	wire hit_acc = ofs == A_ACC;
	wire hit_frc = ofs == A_FRC;
	wire hit_mod = ofs == A_MOD;
	wire hit_fun = ofs == A_FUN;
	wire hit_scc = ofs == A_SCC;
	wire mapped = hit_mcr | hit_isr | hit_msk | hit_flg | hit_dir | hit_dat
		| hit_acc | hit_frc | hit_mod | hit_fun | hit_scc;
	wire [15:0] lane = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	// Read data is loaded in the setup cycle, so it is settled for the
	// whole access phase; unmapped addresses read zero and change nothing.
	// Zero wait state slave, error on unmapped
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// Filtered pin levels: eight port pins, accumulator, clock
	wire [9:0] raw = {ext_clock_pin, accumulator_input_pin, port_pin_in};
	wire [9:0] filt_edge = filt ^ filt_d;
	assign port_level = filt[7:0];
	assign accumulator_pin_state = filt[8];
	assign ext_clock_pin_state = filt[9];

	// Interrupt setup fields
	wire [2:0] lvl = interrupt_setup_register[ISR_LVL +: 3];
	wire [3:0] vbase = interrupt_setup_register[ISR_VB +: 4];
	wire [3:0] padj = interrupt_setup_register[ISR_PA +: 4];

	// R03 mask aligned with flags
	wire [NSRC-1:0] pend = event_flags[NSRC-1:0] & event_mask[NSRC-1:0];
	wire any_pend = |pend;

	// Adjust values of zero or above the source count select nothing.
	// Mask and flag bits above the source count never raise a request.
	// R09 fixed priority with adjust override
	logic [3:0] win_code;
	always_comb begin
		win_code = SRC_ADJ;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (pend[i]) begin
				win_code = 4'(i + 1);
			end
		end
		if (padj != SRC_ADJ && padj <= 4'(NSRC) && pend[padj - 4'h1]) begin
			win_code = SRC_ADJ;
		end
	end

	// R04 one request line per level
	logic [6:0] next_irq_req_n;
	always_comb begin
		next_irq_req_n = 7'h7F;
		if (lvl != 3'h0 && any_pend) begin
			next_irq_req_n[lvl - 3'h1] = 1'b0;
		end
	end

	// An event landing in the clearing cycle wins over the clear, and an
	// event between the read and the write disarms its bit, so software
	// loses an unseen event only if it lands in the setup cycle of the flag read, whose access cycle then arms its bit.
	// R11 flag clear: armed by read, zero write clears, event wins
	wire flg_rd = rd & hit_flg;
	wire flg_wr = wr & hit_flg;
	wire [15:0] ev16 = {{(16 - NSRC){1'b0}}, event_pulse};
	wire [15:0] clr = {16{flg_wr}} & lane & flag_armed & ~pwdata[15:0];
	wire [15:0] next_flags = (event_flags & ~clr) | ev16;
	wire [15:0] next_armed = flg_rd ? event_flags
		: (flag_armed & ~ev16 & ~({16{flg_wr}} & lane));

	// A compare function that owns its pin hides the latched port data;
	// the latch shows again once the function is released.
	// R19 compare owns pin or latched data drives it
	wire [7:0] owns = func_cfg[7:0];
	wire [7:0] cap_en = func_cfg[FUN_CAP +: 8];
	logic [7:0] next_pin_out;
	always_comb begin
		next_pin_out = (owns & oc_level) | (~owns & port_data_register);
		// R15 counter clock on free first compare pin
		if (func_cfg[FUN_CPROUT] && !owns[PIN_OC1]) begin
			next_pin_out[PIN_OC1] = tcnt_clk_en;
		end
	end

	// R20 write to port data kicks capture pins
	wire dat_wr = wr & hit_dat & pstrb[0];
	wire [7:0] next_kick = cap_en & (filt_edge[7:0]
		| ({8{dat_wr}} & (pwdata[7:0] ^ filt[7:0])));

	// The modulator clock output takes precedence over the general output.
	// R22 general outputs use force value and force one
	wire mod_a_gp = modulator_control_register[MOD_F1A]
		| compare_force_register[FRC_FA];
	wire mod_b_gp = modulator_control_register[MOD_F1B]
		| compare_force_register[FRC_FB];
	wire next_mod_a = modulator_control_register[MOD_PPROUT] ? pwm_clk_en
		: (modulator_control_register[MOD_GPA] ? mod_a_gp : pwm_wave[0]);
	wire next_mod_b = modulator_control_register[MOD_GPB] ? mod_b_gp
		: pwm_wave[1];

	// R14 shared register captures only in capture role
	wire shr_cap = ~func_cfg[FUN_ROLE] & next_kick[PIN_SHR];

	// Read data mux
	logic [31:0] rmux;
	always_comb begin
		rmux = 32'h0;
		unique case (1'b1)
			hit_mcr: rmux[3:0] = arbitration_number;
			hit_isr: rmux[11:0] = interrupt_setup_register;
			hit_msk: rmux[15:0] = event_mask;
			hit_flg: rmux[15:0] = event_flags;
			hit_dir: rmux[7:0] = port_direction_register;
			// R18 reads return pin levels
			hit_dat: rmux[7:0] = filt[7:0];
			// R21 pin states in accumulator control
			hit_acc: rmux[7:0] = {filt[8], filt[9],
				accumulator_control_register};
			hit_frc: rmux[1:0] = compare_force_register;
			hit_mod: rmux[4:0] = modulator_control_register;
			hit_fun: rmux[17:0] = func_cfg;
			hit_scc: rmux[15:0] = shared_cc;
			default: rmux = 32'h0;
		endcase
	end

	// Only the second and third stages feed the filter, so a metastable first
	// stage never reaches logic. A level must agree in two samples
	// before it passes, which drops one-clock glitches.
	// R13 two-stage sync then two-sample agreement filter
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_a <= 10'h000;
			sync_b <= 10'h000;
			sync_c <= 10'h000;
			filt <= 10'h000;
			filt_d <= 10'h000;
		end else begin
			sync_a <= raw;
			sync_b <= sync_a;
			sync_c <= sync_b;
			filt <= (sync_b & sync_c) | (filt & (sync_b | sync_c));
			filt_d <= filt;
		end
	end

	// Software registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			arbitration_number <= 4'h0;
			interrupt_setup_register <= 12'h000;
			port_direction_register <= 8'h00;
			port_data_register <= 8'h00;
			accumulator_control_register <= 6'h00;
			compare_force_register <= 2'h0;
			modulator_control_register <= 5'h00;
			func_cfg <= 18'h00000;
		end else if (wr) begin
			// R06 arbitration number held here
			if (hit_mcr && pstrb[0]) arbitration_number <= pwdata[3:0];
			if (hit_isr && pstrb[0]) interrupt_setup_register[7:0] <= pwdata[7:0];
			if (hit_isr && pstrb[1]) interrupt_setup_register[11:8] <= pwdata[11:8];
			// R17 one direction bit per pin
			if (hit_dir && pstrb[0]) port_direction_register <= pwdata[7:0];
			if (dat_wr) port_data_register <= pwdata[7:0];
			if (hit_acc && pstrb[0]) accumulator_control_register <= pwdata[5:0];
			if (hit_frc && pstrb[0]) compare_force_register <= pwdata[1:0];
			if (hit_mod && pstrb[0]) modulator_control_register <= pwdata[4:0];
			if (hit_fun && pstrb[0]) func_cfg[7:0] <= pwdata[7:0];
			if (hit_fun && pstrb[1]) func_cfg[15:8] <= pwdata[15:8];
			if (hit_fun && pstrb[2]) func_cfg[17:16] <= pwdata[17:16];
		end
	end

	// R02 masks byte or word writable, zero at reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			event_mask <= 16'h0000;
		end else if (wr && hit_msk) begin
			event_mask <= (event_mask & ~lane) | (pwdata[15:0] & lane);
		end
	end

	// R23 flags only set by events
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			event_flags <= 16'h0000;
			flag_armed <= 16'h0000;
		end else begin
			event_flags <= next_flags;
			flag_armed <= next_armed;
		end
	end

	// R14 shared register: software value or captured count
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shared_cc <= 16'h0000;
		end else if (shr_cap) begin
			shared_cc <= tcnt;
		end else if (wr && hit_scc) begin
			shared_cc <= (shared_cc & ~lane) | (pwdata[15:0] & lane);
		end
	end
	assign shared_cc_value = shared_cc;

	// Registered outputs: read data, request lines, pins
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h0;
			irq_req_n <= 7'h7F;
			port_pin_out <= 8'h00;
			port_pin_oe <= 8'h00;
			capture_kick <= 8'h00;
			modulator_out_a <= 1'b0;
			modulator_out_b <= 1'b0;
		end else begin
			if (setup) prdata <= rmux;
			// R10 request held while enabled flag set
			irq_req_n <= next_irq_req_n;
			port_pin_out <= next_pin_out;
			// R17 drive enable from direction bit
			port_pin_oe <= port_direction_register;
			capture_kick <= next_kick;
			// R16 modulator clock on first modulator pin
			modulator_out_a <= next_mod_a;
			modulator_out_b <= next_mod_b;
		end
	end

	// R06 acknowledge match on own nonzero level
	wire ack_hit = ack_in.start && lvl != 3'h0 && ack_in.level == lvl
		&& any_pend;
	wire my_bit = arbitration_number[ARB_LAST - arb_bit];
	wire lost = ack_in.step && ~my_bit && ack_in.line;

	// The vector is latched when the acknowledge starts, so a later event
	// cannot change the answer while it is on the bus. A done pulse ends
	// the cycle from any state, which covers an aborted acknowledge.
	// Acknowledge state machine
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			arb_bit <= 2'h0;
			vec_hold <= 8'h00;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (ack_hit) begin
						state <= ST_ARB;
						arb_bit <= 2'h0;
						// R24 winner sampled at acknowledge start
						// R07 vector from base and source code
						vec_hold <= {vbase, win_code};
					end
				end
				ST_ARB: begin
					if (ack_in.done || lost) begin
						state <= ST_IDLE;
					end else if (ack_in.step) begin
						arb_bit <= arb_bit + 2'h1;
						if (arb_bit == ARB_LAST) state <= ST_VEC;
					end
				end
				ST_VEC: begin
					if (ack_in.done) state <= ST_IDLE;
				end
			endcase
		end
	end

	// R07 vector held stable while driven
	// R05 low nibble is the source code
	assign ack_out.vector = vec_hold;
	assign ack_out.vec_oe = state == ST_VEC;
	assign ack_out.arb_out = 1'b1;
	assign ack_out.arb_oe = state == ST_ARB && my_bit;
endmodule
`default_nettype wire

//--- tb/gtm_irq_port_asserts.sv
// Port assertions for the timer interrupt and port block
`timescale 1ns/1ps
`default_nettype none
module gtm_irq_port_asserts (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [gtm_pkg::NSRC-1:0] event_pulse,
	input wire logic [6:0] irq_req_n,
	input wire gtm_pkg::gtm_ack_in_t ack_in,
	input wire gtm_pkg::gtm_ack_out_t ack_out
);
	import gtm_pkg::*;
	// Anything that may move the request lines
	wire cause = psel && penable && pwrite || |event_pulse;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Request lines
	one_line_a: assert property ($onehot0(~irq_req_n))
		else $error("several request lines low");
	irq_cause_a: assert property ($changed(irq_req_n) |->
		$past(cause) || $past(cause, 2)) else $error("request moved alone");
	// Acknowledge answer
	duo_a: assert property (!(ack_out.arb_oe && ack_out.vec_oe))
		else $error("arbitration and vector driven together");
	vec_hold_a: assert property (ack_out.vec_oe && $past(ack_out.vec_oe)
		|-> $stable(ack_out.vector)) else $error("vector moved");
	vec_code_a: assert property (ack_out.vec_oe |->
		ack_out.vector[3:0] <= 4'hB) else $error("bad source code");
	arb_one_a: assert property (ack_out.arb_oe |-> ack_out.arb_out)
		else $error("arbitration drives zero");
	vec_late_a: assert property ($rose(ack_out.vec_oe) |->
		$past(ack_in.step)) else $error("vector before last step");
	done_end_a: assert property (ack_in.done |=>
		!ack_out.vec_oe && !ack_out.arb_oe) else $error("answer after done");
	// Main scenarios reached
	cover property ($rose(ack_out.vec_oe));
	cover property (ack_in.step && ack_in.line && !ack_out.arb_oe);
	cover property ($fell(irq_req_n[6]));
endmodule
bind gtm_irq_port gtm_irq_port_asserts u_chk (.clk, .reset_n, .psel, .penable,
	.pwrite, .event_pulse, .irq_req_n, .ack_in, .ack_out);
`default_nettype wire

//--- tb/gtm_cpu_model.sv
// Processor side of the interrupt acknowledge cycle
`timescale 1ns/1ps
`default_nettype none
module gtm_cpu_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [6:0] irq_req_n,
	input wire gtm_pkg::gtm_ack_out_t ack_out,
	input wire logic [2:0] cpu_mask,
	input wire logic rival,
	input wire logic [1:0] gap,
	output gtm_pkg::gtm_ack_in_t ack_in,
	output logic [7:0] vec_seen,
	output logic [7:0] acks
);
	import gtm_pkg::*;
	logic st = 1'b0, sp = 1'b0, dn = 1'b0;
	logic [2:0] lv = 3'h0, l;
	assign ack_in = '{st, lv, sp, rival | ack_out.arb_oe & ack_out.arb_out, dn};
	initial begin
		vec_seen = 8'h00;
		acks = 8'h00;
		forever begin
			@(posedge clk);
			l = 3'h0;
			for (int i = 0; i < 7; i++)
				if (!irq_req_n[i]) l = 3'(i + 1);
			if (reset_n && l > cpu_mask) begin
				st <= 1'b1;
				lv <= l;
				@(posedge clk);
				st <= 1'b0;
				repeat (4) begin
					if (gap != 2'h0) begin
						sp <= 1'b0;
						repeat (gap) @(posedge clk);
					end
					sp <= 1'b1;
					@(posedge clk);
				end
				sp <= 1'b0;
				@(posedge clk);
				if (ack_out.vec_oe) begin
					vec_seen <= ack_out.vector;
					acks <= acks + 8'h01;
				end
				dn <= 1'b1;
				@(posedge clk);
				dn <= 1'b0;
				// Handler runs until the line drops
				for (int k = 0; k < 3000 && !irq_req_n[l - 1]; k++)
					@(posedge clk);
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/test_gtm_irq_port.sv
// Self-checking bench for the timer interrupt and port block
`timescale 1ns/1ps
`default_nettype none
module test_gtm_irq_port;
	import gtm_pkg::*;
	logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, serr, rival = 1'b0;
	logic accumulator_input_pin = 1'b0, ext_clock_pin = 1'b0;
	logic accumulator_pin_state, ext_clock_pin_state;
	logic modulator_out_a, modulator_out_b;
	logic [7:0] paddr = 8'h00, ext = 8'h00, oc_level = 8'hC3;
	logic [7:0] port_pin_in, port_pin_out, port_pin_oe, port_level;
	logic [7:0] capture_kick, vec_seen, acks;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [3:0] pstrb = 4'h0;
	logic [10:0] event_pulse = 11'h0;
	logic [6:0] irq_req_n;
	logic [2:0] cpu_mask = 3'h7;
	logic [1:0] gap = 2'h0;
	logic tcnt_clk_en = 1'b0, pwm_clk_en = 1'b0;
	logic [15:0] shared_cc_value;
	gtm_ack_in_t ack_in;
	gtm_ack_out_t ack_out;
	int errors = 0, compares = 0, kicks = 0;
	// Pin level: block drives where enabled
	assign port_pin_in = port_pin_oe & port_pin_out | ~port_pin_oe & ext;
	always #5 clk = ~clk;
	always @(posedge clk) kicks <= kicks + capture_kick[0];
	gtm_irq_port dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .event_pulse, .irq_req_n,
		.ack_in, .ack_out, .port_pin_in, .port_pin_out, .port_pin_oe, .oc_level,
		.port_level, .capture_kick, .accumulator_input_pin, .ext_clock_pin,
		.accumulator_pin_state, .ext_clock_pin_state, .tcnt_clk_en,
		.pwm_clk_en, .tcnt(16'h1234), .pwm_wave(2'h0), .modulator_out_a,
		.modulator_out_b, .shared_cc_value);
	gtm_cpu_model cpu (.clk, .reset_n, .irq_req_n, .ack_out, .cpu_mask,
		.rival, .gap, .ack_in, .vec_seen, .acks);
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		compares++;
		if (got !== want) begin
			errors++;
			$display("wrong value at %0t: %h, want %h", $time, got, want);
		end
	endtask
	task automatic wrap_up();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic give_up();
		errors++;
		wrap_up();
	endtask
	// One APB transfer, held until pready
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (n == 20) give_up();
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic ev(input logic [10:0] m);
		event_pulse <= m;
		@(posedge clk);
		event_pulse <= 11'h0;
		repeat (2) @(posedge clk);
	endtask
	task automatic clr();
		bus(1'b0, A_FLG, 32'h0, 4'h0);
		bus(1'b1, A_FLG, 32'h0, 4'h3);
	endtask
	task automatic serve(input logic [10:0] m, input logic [7:0] v);
		int n;
		logic [7:0] a0;
		a0 = acks;
		ev(m);
		for (n = 0; n < 300 && acks === a0; n++) @(posedge clk);
		if (n == 300) give_up();
		chk(vec_seen, v);
		clr();
	endtask
	task automatic t_regs();
		bus(1'b0, A_MSK, 32'h0, 4'h0);
		chk(rdat, 32'h0);
		bus(1'b0, A_ISR, 32'h0, 4'h0);
		chk(rdat, 32'h0);
		bus(1'b1, A_FLG, 32'hFFFF, 4'h3);
		bus(1'b0, A_FLG, 32'h0, 4'h0);
		chk(rdat, 32'h0);
		bus(1'b1, A_MSK, 32'hA5C3, 4'h1);
		bus(1'b0, A_MSK, 32'h0, 4'h0);
		chk(rdat, 32'hC3);
		bus(1'b0, 8'h3C, 32'h0, 4'h0);
		chk(serr, 32'h1);
		$display("registers done");
	endtask
	task automatic t_lvl();
		bus(1'b1, A_MSK, 32'h0, 4'h3);
		ev(11'h001);
		bus(1'b1, A_ISR, 32'h7, 4'h1);
		chk(irq_req_n, 32'h7F);
		bus(1'b1, A_MSK, 32'h2, 4'h3);
		chk(irq_req_n, 32'h7F);
		bus(1'b1, A_MSK, 32'h1, 4'h3);
		for (int l = 1; l < 8; l++) begin
			bus(1'b1, A_ISR, l, 4'h1);
			chk({25'h0, ~irq_req_n}, 32'h1 << (l - 1));
		end
		bus(1'b0, A_FLG, 32'h0, 4'h0);
		ev(11'h001);
		bus(1'b1, A_FLG, 32'h0, 4'h3);
		chk(irq_req_n, 32'h3F);
		bus(1'b1, A_FLG, 32'h0, 4'h3);
		chk(irq_req_n, 32'h3F);
		bus(1'b1, A_ISR, 32'h0, 4'h1);
		chk(irq_req_n, 32'h7F);
		clr();
		bus(1'b1, A_ISR, 32'h7, 4'h1);
		chk(irq_req_n, 32'h7F);
		$display("levels done");
	endtask
	task automatic t_vec();
		logic [7:0] a0;
		cpu_mask <= 3'h0;
		bus(1'b1, A_MCR, 32'h5, 4'h1);
		bus(1'b1, A_ISR, 32'hA3, 4'h1);
		bus(1'b1, A_MSK, 32'h7FF, 4'h3);
		for (int s = 1; s < 12; s++) begin
			gap <= s[1:0];
			serve(11'h1 << (s - 1), {4'hA, 4'(s)});
		end
		serve(11'h024, 8'hA3);
		bus(1'b1, A_ISR, 32'h6A3, 4'h3);
		serve(11'h024, 8'hA0);
		rival <= 1'b1;
		bus(1'b1, A_MCR, 32'hF, 4'h1);
		serve(11'h001, 8'hA1);
		bus(1'b1, A_MCR, 32'h5, 4'h1);
		a0 = acks;
		ev(11'h001);
		repeat (60) @(posedge clk);
		chk(acks, a0);
		clr();
		rival <= 1'b0;
		$display("vectors done");
	endtask
	task automatic t_port();
		int k0;
		logic s;
		k0 = kicks;
		bus(1'b1, A_DIR, 32'hF0, 4'h1);
		bus(1'b1, A_FUN, 32'h0, 4'h7);
		bus(1'b1, A_DAT, 32'hA5, 4'h1);
		ext <= 8'h3C;
		repeat (6) @(posedge clk);
		chk(port_pin_oe, 32'hF0);
		chk(port_pin_out & 8'hF0, 32'hA0);
		bus(1'b0, A_DAT, 32'h0, 4'h0);
		chk(rdat, 32'hAC);
		chk(kicks, k0);
		bus(1'b1, A_FUN, 32'hF0, 4'h1);
		bus(1'b1, A_DAT, 32'h5A, 4'h1);
		chk(port_pin_out & 8'hF0, 32'hC0);
		bus(1'b1, A_FUN, 32'h100, 4'h3);
		chk(port_pin_out & 8'hF0, 32'h50);
		bus(1'b1, A_DAT, 32'h5B, 4'h1);
		chk(kicks, k0 + 1);
		s = 1'b0;
		ext[1] <= 1'b1;
		accumulator_input_pin <= 1'b1;
		@(posedge clk);
		ext[1] <= 1'b0;
		repeat (8) begin
			@(posedge clk);
			s = s | port_level[1];
		end
		chk(s, 32'h0);
		ext[1] <= 1'b1;
		repeat (8) @(posedge clk);
		chk(port_level[1], 32'h1);
		bus(1'b0, A_ACC, 32'h0, 4'h0);
		chk(rdat[7:6], 32'h2);
		bus(1'b1, A_MOD, 32'h1A, 4'h1);
		chk({modulator_out_a, modulator_out_b}, 32'h2);
		bus(1'b1, A_FRC, 32'h2, 4'h1);
		chk(modulator_out_b, 32'h1);
		$display("port done");
	endtask
	task automatic t_clk();
		// capture role takes the counter on a port write kick
		bus(1'b1, A_FUN, 32'h28000, 4'h7);
		bus(1'b1, A_DAT, 32'hDB, 4'h1);
		chk(shared_cc_value, 32'h1234);
		// counter clock on the free first compare pin
		tcnt_clk_en <= 1'b1;
		repeat (2) @(posedge clk);
		chk(port_pin_out[PIN_OC1], 32'h1);
		tcnt_clk_en <= 1'b0;
		repeat (2) @(posedge clk);
		chk(port_pin_out[PIN_OC1], 32'h0);
		// compare role keeps the software value
		bus(1'b1, A_FUN, 32'h38000, 4'h7);
		bus(1'b1, A_SCC, 32'hBEEF, 4'h3);
		bus(1'b1, A_DAT, 32'h5B, 4'h1);
		repeat (6) @(posedge clk);
		bus(1'b0, A_SCC, 32'h0, 4'h0);
		chk(rdat, 32'hBEEF);
		// modulator clock on the first modulator pin
		bus(1'b1, A_MOD, 32'h1, 4'h1);
		pwm_clk_en <= 1'b1;
		repeat (2) @(posedge clk);
		chk(modulator_out_a, 32'h1);
		pwm_clk_en <= 1'b0;
		repeat (2) @(posedge clk);
		chk(modulator_out_a, 32'h0);
		$display("clocks done");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_lvl();
		t_vec();
		t_port();
		t_clk();
		wrap_up();
	end
endmodule
`default_nettype wire
